// file: include/ffm_pkg.sv
// Shared constants for the freefall and motion event detector.
// Assumes a 50 MHz system clock and 10-bit two's complement axis samples.
package ffm_pkg;

  // Register offsets on the register port
  localparam logic [7:0] ADDR_CFG = 8'h15;
  localparam logic [7:0] ADDR_SRC = 8'h16;
  localparam logic [7:0] ADDR_THS = 8'h17;
  localparam logic [7:0] ADDR_CNT = 8'h18;

  // Field positions
  localparam int CFG_LATCH_BIT = 7;
  localparam int CFG_COMBINE_BIT = 6;
  localparam int CFG_Z_EN_BIT = 5;
  localparam int CFG_Y_EN_BIT = 4;
  localparam int CFG_X_EN_BIT = 3;
  localparam int SRC_ACTIVE_BIT = 7;
  localparam int THS_MODE_BIT = 7;
  localparam int THS_MSB = 6;

  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [7:0] THS_RESET = 8'h00;
  localparam logic [7:0] CNT_RESET = 8'h00;
  localparam logic [7:0] SRC_RESET = 8'h00;

  // Widths
  localparam int SAMPLE_W = 10;
  localparam int THS_W = 7;
  localparam int MAG_W = 11;

  // Timing: the debounce step is a whole multiple of the 1.25 ms base step
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned BASE_STEP_NS = 1250000;
  localparam int unsigned BASE_STEP_CYCLES = BASE_STEP_NS / CLK_PERIOD_NS;

  // Step period in units of the base step
  localparam logic [7:0] STEP_X1 = 8'h01;
  localparam logic [7:0] STEP_X2 = 8'h02;
  localparam logic [7:0] STEP_X4 = 8'h04;
  localparam logic [7:0] STEP_X8 = 8'h08;
  localparam logic [7:0] STEP_X16 = 8'h10;
  localparam logic [7:0] STEP_X64 = 8'h40;
  localparam logic [7:0] STEP_X128 = 8'h80;

  // Threshold alignment: left shift from a threshold count to sample LSBs per range
  localparam logic [2:0] SHIFT_2G = 3'h4;
  localparam logic [2:0] SHIFT_4G = 3'h3;
  localparam logic [2:0] SHIFT_8G = 3'h2;

  typedef enum logic [1:0] {
    OSM_NORMAL = 2'h0,
    OSM_LOW_NOISE = 2'h1,
    OSM_HIGH_RES = 2'h2,
    OSM_LOW_POWER = 2'h3
  } ffm_osm_e;

  typedef enum logic [1:0] {
    RANGE_2G = 2'h0,
    RANGE_4G = 2'h1,
    RANGE_8G = 2'h2,
    RANGE_RSVD = 2'h3
  } ffm_range_e;

endpackage

// file: src/ffm_axis_compare.sv
// One axis magnitude comparator for the event detector.
// Assumes the sample is a signed 10-bit value at the selected full scale.
`timescale 1ns/1ps
module ffm_axis_compare (
  input wire logic [ffm_pkg::SAMPLE_W-1:0] sample,
  input wire logic [ffm_pkg::THS_W-1:0] threshold,
  input wire ffm_pkg::ffm_range_e range_sel,
  output logic above,
  output logic negative
);
  logic [ffm_pkg::MAG_W-1:0] mag;
  logic [ffm_pkg::MAG_W-1:0] limit;
  logic [2:0] shift;

  always_comb begin
    negative = sample[ffm_pkg::SAMPLE_W-1];
    // -512 folds to 512, which still fits the unsigned field
    mag = {1'b0, negative ? ffm_pkg::SAMPLE_W'(~sample + 1'b1) : sample};
    unique case (range_sel)
      ffm_pkg::RANGE_2G: shift = ffm_pkg::SHIFT_2G;
      ffm_pkg::RANGE_4G: shift = ffm_pkg::SHIFT_4G;
      default: shift = ffm_pkg::SHIFT_8G;
    endcase
    // Threshold is always 8 g scaled, so align it to the sample scale
    limit = ffm_pkg::MAG_W'({4'h0, threshold} << shift); // (R9)
    above = mag > limit; // (R3)
  end
endmodule

// file: src/ffm_detector.sv
// Freefall and motion event detector with its four registers.
// Assumes a register port already decoded from the serial host interface,
// and axis samples that are steady between output-data-rate updates.
//
// Notes on behaviour
// (R1) Active flag, source bit 7, sets when debounced axis combination holds.
// (R2) Interrupt is active flag gated by enable, routed by route bit.
// (R3) Motion: axis true when magnitude strictly above threshold.
// (R4) Freefall: true only when all enabled magnitudes at or below threshold.
// (R5) Source register 0x16 read-only: active, zero, Z/Y/X event and sign.
// (R6) Axis event and sign read zero while that axis is disabled.
// (R7) Sign flag: 0 positive, 1 negative, reset 0.
// (R8) Threshold 0x17 bits 6..0, unsigned 7-bit, shared, reset zero.
// (R9) Threshold 0.063 g per count, compared on 8 g scale always.
// (R10) Mode bit set: counter cleared on any step without the condition.
// (R11) Mode bit clear: counter decremented on false steps, stops at zero.
// (R12) Count register 0x18, 8-bit read-write, reset zero.
// (R13) Event flag set when internal counter equals count register.
// (R14) Counter saturates at the count register value.
// (R15) Counter step period follows data rate and oversampling mode.
// (R16) Combination select 0 gives AND (freefall), 1 gives OR (motion).
// (R17) Latch enabled: flags freeze on active; source read clears them.
// (R18) Only axes with their detect enable set take part.
// (R19) Counter increments once per step while condition holds.
`timescale 1ns/1ps
module ffm_detector #(
  parameter int unsigned BASE_STEP_CYCLES = ffm_pkg::BASE_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rdata,
  input wire logic [ffm_pkg::SAMPLE_W-1:0] x_sample,
  input wire logic [ffm_pkg::SAMPLE_W-1:0] y_sample,
  input wire logic [ffm_pkg::SAMPLE_W-1:0] z_sample,
  input wire logic [1:0] full_scale_sel,
  input wire logic [2:0] output_sample_rate,
  input wire logic [1:0] oversampling_mode,
  input wire logic motion_interrupt_enable,
  input wire logic motion_interrupt_route,
  output logic int1_out,
  output logic int2_out,
  output logic event_active_flag
);
  localparam int BW = $clog2(BASE_STEP_CYCLES + 1);
  localparam logic [BW-1:0] BASE_LAST = BW'(BASE_STEP_CYCLES - 1);

  typedef struct packed {
    logic [7:0] cfg_r;
    logic [7:0] ths_r;
    logic [7:0] count_r;
    logic [7:0] dbc_r;
    logic active_r;
    logic [5:0] flags_r;
    logic [BW-1:0] base_r;
    logic [7:0] mult_r;
    logic [7:0] rdata_r;
    logic int1_r;
    logic int2_r;
  } ffm_state_s;

  ffm_state_s st_r;
  ffm_state_s st_nxt;

  logic [2:0] axis_above;
  logic [2:0] axis_neg;
  logic [2:0] axis_en;
  logic [ffm_pkg::THS_W-1:0] threshold;
  ffm_pkg::ffm_range_e range_sel;

  assign range_sel = ffm_pkg::ffm_range_e'(full_scale_sel);
  assign threshold = st_r.ths_r[ffm_pkg::THS_MSB:0]; // (R8)
  assign axis_en = {st_r.cfg_r[ffm_pkg::CFG_Z_EN_BIT],
                    st_r.cfg_r[ffm_pkg::CFG_Y_EN_BIT],
                    st_r.cfg_r[ffm_pkg::CFG_X_EN_BIT]};

  ffm_axis_compare u_cmp_x (
    .sample(x_sample),
    .threshold(threshold),
    .range_sel(range_sel),
    .above(axis_above[0]),
    .negative(axis_neg[0])
  );

  ffm_axis_compare u_cmp_y (
    .sample(y_sample),
    .threshold(threshold),
    .range_sel(range_sel),
    .above(axis_above[1]),
    .negative(axis_neg[1])
  );

  ffm_axis_compare u_cmp_z (
    .sample(z_sample),
    .threshold(threshold),
    .range_sel(range_sel),
    .above(axis_above[2]),
    .negative(axis_neg[2])
  );

  // Base steps per debounce step, by data rate and oversampling mode
  function automatic logic [7:0] step_mult(input logic [2:0] rate,
                                           input logic [1:0] mode);
    logic [7:0] m;
    m = ffm_pkg::STEP_X1;
    unique case (rate)
      3'h0: m = ffm_pkg::STEP_X1;
      3'h1: m = ffm_pkg::STEP_X2;
      3'h2: m = ffm_pkg::STEP_X4;
      3'h3: m = ffm_pkg::STEP_X8;
      3'h4: m = ffm_pkg::STEP_X16;
      3'h5: m = ffm_pkg::STEP_X64;
      default: m = (mode == ffm_pkg::OSM_LOW_POWER) ?
                   ffm_pkg::STEP_X128 : ffm_pkg::STEP_X64;
    endcase
    // Normal mode stops at 20 ms, high resolution at 2.5 ms
    if (mode == ffm_pkg::OSM_NORMAL && rate > 3'h4) begin
      m = ffm_pkg::STEP_X16;
    end
    if (mode == ffm_pkg::OSM_HIGH_RES && rate != 3'h0) begin
      m = ffm_pkg::STEP_X2;
    end
    return m;
  endfunction

  always_comb begin
    logic base_tick;
    logic step_tick;
    logic [7:0] mult_last;
    logic latch_en;
    logic motion_sel;
    logic cond;
    logic [5:0] live_flags;
    logic [7:0] src_view;
    logic src_clear;
    st_nxt = st_r;
    base_tick = 1'b0;
    step_tick = 1'b0;
    mult_last = step_mult(output_sample_rate, oversampling_mode) - 8'h01;
    latch_en = st_r.cfg_r[ffm_pkg::CFG_LATCH_BIT];
    motion_sel = st_r.cfg_r[ffm_pkg::CFG_COMBINE_BIT];
    cond = 1'b0;
    live_flags = 6'h00;
    src_view = 8'h00;
    src_clear = 1'b0;

    // Step timer; a rate change mid-step wraps at the new length
    if (st_r.base_r >= BASE_LAST) begin
      st_nxt.base_r = '0;
      base_tick = 1'b1;
    end else begin
      st_nxt.base_r = st_r.base_r + 1'b1;
    end
    if (base_tick) begin
      if (st_r.mult_r >= mult_last) begin
        st_nxt.mult_r = 8'h00;
        step_tick = 1'b1; // (R15)
      end else begin
        st_nxt.mult_r = st_r.mult_r + 8'h01;
      end
    end

    // Per-axis status pairs, zero for disabled axes
    for (int i = 0; i < 3; i++) begin
      live_flags[2*i+1] = axis_en[i] & axis_above[i]; // (R6) (R18)
      live_flags[2*i] = axis_en[i] & axis_above[i] & axis_neg[i]; // (R7)
    end

    // Axis combination over enabled axes only
    if (motion_sel) begin
      cond = |(axis_en & axis_above); // (R3) (R16)
    end else begin
      cond = (axis_en != 3'h0) && ((axis_en & axis_above) == 3'h0); // (R4)
    end

    // Source view with enables applied at read time as well
    src_view[ffm_pkg::SRC_ACTIVE_BIT] = st_r.active_r; // (R5)
    for (int i = 0; i < 3; i++) begin
      src_view[2*i+1] = st_r.flags_r[2*i+1] & axis_en[i]; // (R6)
      src_view[2*i] = st_r.flags_r[2*i] & axis_en[i];
    end

    // Register reads: data appears one cycle after the strobe
    if (reg_rd_en) begin
      unique case (reg_addr)
        ffm_pkg::ADDR_CFG: st_nxt.rdata_r = {st_r.cfg_r[7:3], 3'h0};
        ffm_pkg::ADDR_SRC: st_nxt.rdata_r = src_view; // (R5)
        ffm_pkg::ADDR_THS: st_nxt.rdata_r = st_r.ths_r;
        ffm_pkg::ADDR_CNT: st_nxt.rdata_r = st_r.count_r; // (R12)
        default: st_nxt.rdata_r = 8'h00;
      endcase
      src_clear = latch_en && (reg_addr == ffm_pkg::ADDR_SRC);
    end

    // Register writes; the source register ignores writes
    if (reg_wr_en) begin
      unique case (reg_addr)
        ffm_pkg::ADDR_CFG: st_nxt.cfg_r = {reg_wdata[7:3], 3'h0};
        ffm_pkg::ADDR_THS: st_nxt.ths_r = reg_wdata; // (R8)
        ffm_pkg::ADDR_CNT: st_nxt.count_r = reg_wdata; // (R12)
        default: st_nxt.cfg_r = st_r.cfg_r;
      endcase
    end

    // Latched read clear comes first so a same-step event still sets
    if (src_clear) begin
      st_nxt.active_r = 1'b0; // (R17)
      st_nxt.flags_r = 6'h00;
      st_nxt.dbc_r = 8'h00;
    end

    if (step_tick) begin
      if (cond) begin
        if (st_nxt.dbc_r < st_r.count_r) begin
          st_nxt.dbc_r = st_nxt.dbc_r + 8'h01; // (R19)
        end else begin
          st_nxt.dbc_r = st_r.count_r; // (R14)
        end
      end else if (st_r.ths_r[ffm_pkg::THS_MODE_BIT]) begin
        st_nxt.dbc_r = 8'h00; // (R10)
      end else if (st_nxt.dbc_r != 8'h00) begin
        st_nxt.dbc_r = st_nxt.dbc_r - 8'h01; // (R11)
      end

      if (latch_en) begin
        // Held until the source register is read
        if (cond && st_nxt.dbc_r == st_r.count_r) begin
          st_nxt.active_r = 1'b1; // (R1) (R13) (R17)
        end
        if (!st_nxt.active_r || !st_r.active_r || src_clear) begin
          st_nxt.flags_r = live_flags; // (R17)
        end
      end else begin
        // Live mode: a decrementing counter holds the flag off the edge
        if (cond) begin
          st_nxt.active_r = st_nxt.dbc_r == st_r.count_r; // (R1) (R13)
        end else begin
          st_nxt.active_r = st_r.active_r && st_nxt.dbc_r != 8'h00;
        end
        st_nxt.flags_r = live_flags;
      end
    end

    st_nxt.int1_r = st_nxt.active_r & motion_interrupt_enable &
                    motion_interrupt_route; // (R2)
    st_nxt.int2_r = st_nxt.active_r & motion_interrupt_enable &
                    ~motion_interrupt_route; // (R2)
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '{cfg_r: ffm_pkg::CFG_RESET,
                ths_r: ffm_pkg::THS_RESET,
                count_r: ffm_pkg::CNT_RESET,
                dbc_r: 8'h00,
                active_r: 1'b0,
                flags_r: 6'h00,
                base_r: '0,
                mult_r: 8'h00,
                rdata_r: ffm_pkg::SRC_RESET,
                int1_r: 1'b0,
                int2_r: 1'b0};
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata_r;
  assign int1_out = st_r.int1_r;
  assign int2_out = st_r.int2_r;
  assign event_active_flag = st_r.active_r;

endmodule

// file: testbench/ffm_detector_chk.sv
// Port-level checks for the freefall and motion detector.
// Assumes it is bound to ffm_detector and sees only its ports.
`timescale 1ns/1ps
module ffm_detector_chk #(
  parameter int unsigned BASE_STEP_CYCLES = 4
) (
  input logic clk,
  input logic rst,
  input logic ce,
  input logic [7:0] reg_addr,
  input logic reg_rd_en,
  input logic [7:0] reg_rdata,
  input logic motion_interrupt_enable,
  input logic motion_interrupt_route,
  input logic int1_out,
  input logic int2_out,
  input logic event_active_flag
);
  logic rd_q;
  logic [7:0] a_q;

  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  // Remembers which read was taken on the previous edge
  always_ff @(posedge clk) begin
    rd_q <= reg_rd_en && ce && !rst;
    a_q <= reg_addr;
  end

  int1_source_a: assert property (int1_out |-> event_active_flag && !int2_out)
    else $error("int1 high without active flag");
  int2_source_a: assert property (int2_out |-> event_active_flag)
    else $error("int2 high without active flag");
  int1_route_a: assert property ($past(ce) && !$past(rst) &&
    event_active_flag && $past(motion_interrupt_enable) &&
    $past(motion_interrupt_route) |-> int1_out)
    else $error("enabled event not routed to int1");
  rdata_hold_a: assert property (!rd_q && !$past(rst) |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  src_zero_bit_a: assert property (
    rd_q && a_q == ffm_pkg::ADDR_SRC |-> !reg_rdata[6])
    else $error("source bit 6 not zero");
  src_active_a: assert property (rd_q && a_q == ffm_pkg::ADDR_SRC |->
    reg_rdata[7] == $past(event_active_flag))
    else $error("source bit 7 differs from active flag");
  cfg_low_zero_a: assert property (
    rd_q && a_q == ffm_pkg::ADDR_CFG |-> reg_rdata[2:0] == 3'h0)
    else $error("config low bits not zero");
  unmapped_zero_a: assert property (rd_q && (a_q < ffm_pkg::ADDR_CFG ||
    a_q > ffm_pkg::ADDR_CNT) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  freeze_ce_a: assert property (!ce |=> $stable(event_active_flag) &&
    $stable(int1_out) && $stable(int2_out))
    else $error("state moved while clock enable low");
endmodule

// file: testbench/ffm_sample_src.sv
// Axis sample source standing in for the sensor front end.
// Assumes the bench pulses upd for one cycle to load new samples.
`timescale 1ns/1ps
module ffm_sample_src (
  input logic clk,
  input logic upd,
  input logic [29:0] nxt,
  output logic [9:0] x_s,
  output logic [9:0] y_s,
  output logic [9:0] z_s
);
  initial begin
    {z_s, y_s, x_s} = '0;
  end
  // Samples change only on upd, so they stay steady between rate ticks
  always @(posedge clk) begin
    if (upd) begin
      {z_s, y_s, x_s} <= nxt;
    end
  end
endmodule

// file: testbench/freefall_motion_event_detector_bench.sv
// Self-checking bench for the freefall and motion detector.
// Assumes a debounce step of four clocks and the fastest sample rate.
`timescale 1ns/1ps
module freefall_motion_event_detector_bench;
  logic clk, rst, ce, wr, rd, upd, i_en, i_rt, rd_d, sg, i1, i2, act;
  logic [7:0] addr, wd, rdata;
  logic [1:0] fs;
  logic [29:0] nxt;
  logic [9:0] xs, ys, zs, hi;
  logic [7:0] exp_q[$];
  int err_total, total_checks, seed, r, t;

  ffm_detector #(.BASE_STEP_CYCLES(4)) DUT (.clk(clk), .rst(rst), .ce(ce),
    .reg_addr(addr), .reg_wr_en(wr), .reg_wdata(wd), .reg_rd_en(rd),
    .reg_rdata(rdata), .x_sample(xs), .y_sample(ys), .z_sample(zs),
    .full_scale_sel(fs), .output_sample_rate(3'h0),
    .oversampling_mode(2'h0), .motion_interrupt_enable(i_en),
    .motion_interrupt_route(i_rt), .int1_out(i1), .int2_out(i2),
    .event_active_flag(act));
  ffm_sample_src u_src (.clk(clk), .upd(upd), .nxt(nxt), .x_s(xs),
    .y_s(ys), .z_s(zs));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  function automatic logic [9:0] s10(input int v);
    return v[9:0];
  endfunction
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
    cyc(1);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    cyc(1);
    rd <= 1'b0;
    cyc(1);
  endtask
  task automatic put(input logic [9:0] x, input logic [9:0] y,
                     input logic [9:0] z);
    nxt <= {z, y, x};
    upd <= 1'b1;
    cyc(1);
    upd <= 1'b0;
    cyc(1);
  endtask
  // A wait that runs out counts as a mismatch and ends the run
  task automatic wait_act(input logic v);
    int n;
    n = 0;
    while (act !== v && n < 60) begin
      cyc(1);
      n++;
    end
    chk({7'h00, act}, {7'h00, v});
    if (act !== v) final_report();
  endtask

  // Read data shows one cycle after the read edge
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) chk(rdata, exp_q.pop_front());
  end

  initial begin
    seed = 32'h19a7;
    err_total = 0;
    total_checks = 0;
    {rst, ce, wr, rd, upd, i_en, i_rt} = 7'h60;
    {addr, wd, fs, nxt} = '0;
    cyc(8);
    rst <= 1'b0;
    cyc(1);
    rd_reg(8'h15, 8'h00);
    wr_reg(8'h15, 8'hff);
    rd_reg(8'h15, 8'hf8);
    wr_reg(8'h15, 8'h40);
    wr_reg(8'h16, 8'hff);
    cyc(12);
    rd_reg(8'h16, 8'h00);
    rd_reg(8'h17, 8'h00);
    rd_reg(8'h18, 8'h00);
    rd_reg(8'h40, 8'h00);
    $display("register access done");
    r = $random(seed);
    t = 1 + (r & 30);
    sg = r[0];
    // At 2 g one threshold count is 16 sample LSBs
    hi = s10(16 * t + 1);
    wr_reg(8'h17, t[7:0]);
    i_en <= 1'b1;
    i_rt <= 1'b1;
    wr_reg(8'h15, 8'hf8);
    put(sg ? -hi : hi, s10(16 * t), 10'h000);
    wait_act(1'b1);
    chk({6'h00, i1, i2}, 8'h02);
    ce <= 1'b0;
    cyc(5);
    ce <= 1'b1;
    put(10'h000, 10'h000, 10'h000);
    rd_reg(8'h16, {7'h41, sg});
    cyc(12);
    rd_reg(8'h16, 8'h00);
    wr_reg(8'h15, 8'hf0);
    put(hi, 10'h000, 10'h000);
    cyc(12);
    rd_reg(8'h16, 8'h00);
    put(10'h000, 10'h000, hi);
    wait_act(1'b1);
    put(10'h000, 10'h000, 10'h000);
    rd_reg(8'h16, 8'ha0);
    $display("motion latch done");
    fs <= 2'h1;
    i_rt <= 1'b0;
    wr_reg(8'h15, 8'h38);
    put(s10(8 * t), s10(-8 * t), 10'h000);
    wait_act(1'b1);
    chk({6'h00, i1, i2}, 8'h01);
    i_en <= 1'b0;
    cyc(2);
    chk({6'h00, i1, i2}, 8'h00);
    put(hi, 10'h000, 10'h000);
    wait_act(1'b0);
    rd_reg(8'h16, 8'h02);
    $display("freefall done");
    put(10'h000, 10'h000, 10'h000);
    wr_reg(8'h18, 8'h03);
    wr_reg(8'h17, {1'b1, t[6:0]});
    wr_reg(8'h15, 8'h48);
    cyc(16);
    put(hi, 10'h000, 10'h000);
    cyc(5);
    chk({7'h00, act}, 8'h00);
    wait_act(1'b1);
    put(10'h000, 10'h000, 10'h000);
    cyc(4);
    chk({7'h00, act}, 8'h00);
    wr_reg(8'h17, t[7:0]);
    put(hi, 10'h000, 10'h000);
    wait_act(1'b1);
    cyc(16);
    put(10'h000, 10'h000, 10'h000);
    cyc(4);
    chk({7'h00, act}, 8'h01);
    cyc(10);
    chk({7'h00, act}, 8'h00);
    $display("debounce done");
    final_report();
  end
endmodule

bind ffm_detector ffm_detector_chk #(
  .BASE_STEP_CYCLES(BASE_STEP_CYCLES)
) u_chk (.*);
